// File: src/lrsc_map.svh
// Constants for the link receiver/transmitter state control block
`ifndef LRSC_MAP_SVH
`define LRSC_MAP_SVH
`define LRSC_DATA_W 8
`define LRSC_FIFO_DEPTH 32
`define LRSC_FIFO_AW 5
`define LRSC_RST_IDLE_BYTES 2'h0
`define LRSC_WORD_LAST 2'h3
`endif

// File: src/lrsc_pkg.sv
// Types for the link receiver/transmitter state control block
package lrsc_pkg;
  typedef enum logic [1:0] {
    RX_RESET,
    RX_LOS,
    RX_SYNC
  } lrsc_rx_state_type;
  typedef enum logic [1:0] {
    TX_NOT_ENABLED,
    TX_WORKING,
    TX_OPEN_FIBRE,
    TX_FAILURE
  } lrsc_tx_state_type;
  typedef struct packed {
    logic [7:0] data;
    logic ordered;
  } lrsc_byte_type;
endpackage

// File: src/lrsc_fifo.sv
// Byte FIFO between port requests and the transmit path
`timescale 1ns/10ps
`include "lrsc_map.svh"
module lrsc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready,
  input wire logic i_flush
);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } lrsc_fifo_state_type;
  lrsc_fifo_state_type st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;
  assign empty = st.wr == st.rd;
  assign full = (st.wr[AW] != st.rd[AW]) &&
    (st.wr[AW-1:0] == st.rd[AW-1:0]);
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[st.rd[AW-1:0]];
  always_comb begin
    next_st = st;
    if (i_flush) begin
      next_st.rd = st.wr;
    end else begin
      if (i_valid && !full) begin
        next_st.wr = st.wr + 1'b1;
      end
      if (i_ready && !empty) begin
        next_st.rd = st.rd + 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (i_valid && !full && !i_flush) begin
      mem[st.wr[AW-1:0]] <= i_data;
    end
  end
endmodule

// File: src/lrsc_top.sv
// Receiver and transmitter state control for one serial link
// Overview of operation
// - Receiver reset forces Reset, not operational, held until reset removed.
// - Receiver starts in Loss-Of-Synchronization once initialization completes.
// - No Synchronization-Acquired until receiver path width is fixed.
// - Sync acquired enters sync; lost sync or signal loss returns to LOS.
// - Leaving reset or power-on makes the receiver enter LOS.
// - After signal loss, stay in LOS until signal back and sync regained.
// - Receiver loopback accepted only in LOS or Synchronization-Acquired.
// - Working and enabled transmitter continuously drives the encoded stream; here O_LINE_VALID is high only while the FIFO holds bytes.
// - Stop request gives Not-Enabled, hazard gives Open-Fibre; both operational.
// - Not-Enabled and Open-Fibre emit only laser safety signalling.
// - Working on enable without hazard, or hazard clear without pending disable.
// - Not-Enabled on init, disable without hazard, or clear with disable pending.
// - Transmitter defaults to Not-Enabled after initialization.
// - Open-Fibre holds until hazard clears; requests only steer the exit.
// - Failure seen while Working: enter Failure, not operational, report, hold.
// - Monitoring is optional; here failure is the monitor's fault input.
// - Working sends port bytes, word alignment fixed on entry to Working.
// - No Working until transmitter path width is fixed.
// - Transmitter loopback accepted in Working, Open-Fibre, Not-Enabled only.
`timescale 1ns/10ps
`include "lrsc_map.svh"
module lrsc_top (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_RX_RESET,
  input wire logic I_RX_WIDTH_FIXED,
  input wire logic I_RX_SYNC_ACQUIRED,
  input wire logic I_RX_LOS_DONE,
  input wire logic I_RX_SIGNAL_LOST,
  input wire logic I_RX_LOOPBACK_REQ,
  input wire logic I_TX_WIDTH_FIXED,
  input wire logic I_TX_ENABLE_REQ,
  input wire logic I_TX_DISABLE_REQ,
  input wire logic I_EXT_DISABLE,
  input wire logic I_OPEN_FIBRE_SAFETY_CONTROL,
  input wire logic I_SAFETY_SIGNAL,
  input wire logic I_TX_MONITOR_FAULT,
  input wire logic I_TX_RESTORE,
  input wire logic I_TX_LOOPBACK_REQ,
  input wire logic [7:0] I_TX_DATA,
  input wire logic I_TX_ORDERED,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  output logic O_RX_OPERATIONAL,
  output logic [1:0] O_RX_STATE,
  output logic O_RX_LOOPBACK,
  output logic [1:0] O_TX_STATE,
  output logic O_TX_OPERATIONAL,
  output logic O_TX_FAILURE,
  output logic O_TX_LOOPBACK,
  output logic O_DISABLE_PENDING,
  output logic [7:0] O_LINE_DATA,
  output logic O_LINE_ORDERED,
  output logic O_LINE_VALID,
  output logic O_LASER_ON,
  output logic [1:0] O_LINE_BYTE_POS
);
  typedef struct packed {
    logic [1:0] s_rx_rst, s_width_rx, s_sync, s_los, s_sig;
    logic [1:0] s_rxlb, s_txw, s_en, s_dis, s_ext, s_ofc, s_saf;
    logic [1:0] s_mon, s_rest, s_txlb;
    lrsc_pkg::lrsc_rx_state_type rx;
    lrsc_pkg::lrsc_tx_state_type tx;
    logic pend_dis;
    logic rx_lb;
    logic tx_lb;
    logic fail;
    logic rx_op;
    logic tx_op;
    logic [1:0] pos;
    lrsc_pkg::lrsc_byte_type line;
    logic line_valid;
    logic laser;
  } lrsc_state_type;
  lrsc_state_type st, next_st;
  lrsc_pkg::lrsc_byte_type fifo_in, fifo_out;
  logic fifo_valid, fifo_ready, fifo_pop, fifo_flush;
  // Two-flop synchroniser step; only bit 1 is ever read by logic
  function automatic logic [1:0] sync2(input logic [1:0] s, input logic d);
    sync2 = {s[0], d};
  endfunction
  assign fifo_in = {I_TX_DATA, I_TX_ORDERED};
  assign fifo_pop = st.tx == lrsc_pkg::TX_WORKING;
  assign fifo_flush = st.tx != lrsc_pkg::TX_WORKING && st.pos == 2'h0;
  lrsc_fifo #(
    .WIDTH($bits(lrsc_pkg::lrsc_byte_type)),
    .DEPTH(`LRSC_FIFO_DEPTH),
    .AW(`LRSC_FIFO_AW)
  ) u_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_data(fifo_in),
    .i_valid(I_TX_VALID),
    .o_ready(fifo_ready),
    .o_data(fifo_out),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .i_flush(fifo_flush)
  );
  always_comb begin
    next_st = st;
    next_st.s_rx_rst = sync2(st.s_rx_rst, I_RX_RESET);
    next_st.s_width_rx = sync2(st.s_width_rx, I_RX_WIDTH_FIXED);
    next_st.s_sync = sync2(st.s_sync, I_RX_SYNC_ACQUIRED);
    next_st.s_los = sync2(st.s_los, I_RX_LOS_DONE);
    next_st.s_sig = sync2(st.s_sig, I_RX_SIGNAL_LOST);
    next_st.s_rxlb = sync2(st.s_rxlb, I_RX_LOOPBACK_REQ);
    next_st.s_txw = sync2(st.s_txw, I_TX_WIDTH_FIXED);
    next_st.s_en = sync2(st.s_en, I_TX_ENABLE_REQ);
    next_st.s_dis = sync2(st.s_dis, I_TX_DISABLE_REQ);
    next_st.s_ext = sync2(st.s_ext, I_EXT_DISABLE);
    next_st.s_ofc = sync2(st.s_ofc, I_OPEN_FIBRE_SAFETY_CONTROL);
    next_st.s_saf = sync2(st.s_saf, I_SAFETY_SIGNAL);
    next_st.s_mon = sync2(st.s_mon, I_TX_MONITOR_FAULT);
    next_st.s_rest = sync2(st.s_rest, I_TX_RESTORE);
    next_st.s_txlb = sync2(st.s_txlb, I_TX_LOOPBACK_REQ);
    // Receiver
    if (st.s_rx_rst[1]) begin
      next_st.rx = lrsc_pkg::RX_RESET;
    end else begin
      case (st.rx)
        lrsc_pkg::RX_RESET: next_st.rx = lrsc_pkg::RX_LOS;
        lrsc_pkg::RX_LOS: begin
          // Signal must be back before sync counts
          if (st.s_sync[1] && st.s_width_rx[1] && !st.s_sig[1]) begin
            next_st.rx = lrsc_pkg::RX_SYNC;
          end
        end
        lrsc_pkg::RX_SYNC: begin
          if (st.s_los[1] || st.s_sig[1]) begin
            next_st.rx = lrsc_pkg::RX_LOS;
          end
        end
        default: next_st.rx = lrsc_pkg::RX_RESET;
      endcase
    end
    next_st.rx_lb = st.s_rxlb[1] && next_st.rx != lrsc_pkg::RX_RESET;
    // Status pins come from flops so they never glitch on a decode
    next_st.rx_op = next_st.rx != lrsc_pkg::RX_RESET;
    // Disable request wins while asserted; enable clears only without it
    if (st.s_dis[1]) begin
      next_st.pend_dis = 1'b1;
    end else if (st.s_en[1]) begin
      next_st.pend_dis = 1'b0;
    end
    // Transmitter
    case (st.tx)
      lrsc_pkg::TX_NOT_ENABLED, lrsc_pkg::TX_WORKING: begin
        if (st.s_ofc[1]) begin
          next_st.tx = lrsc_pkg::TX_OPEN_FIBRE;
        end else if (st.tx == lrsc_pkg::TX_WORKING && st.s_mon[1]) begin
          next_st.tx = lrsc_pkg::TX_FAILURE;
        end else if (st.s_dis[1] || st.s_ext[1]) begin
          next_st.tx = lrsc_pkg::TX_NOT_ENABLED;
        end else if (st.s_en[1] && st.s_txw[1]) begin
          next_st.tx = lrsc_pkg::TX_WORKING;
        end
      end
      lrsc_pkg::TX_OPEN_FIBRE: begin
        if (!st.s_ofc[1]) begin
          if (next_st.pend_dis || st.s_ext[1] || !st.s_txw[1]) begin
            next_st.tx = lrsc_pkg::TX_NOT_ENABLED;
          end else begin
            next_st.tx = lrsc_pkg::TX_WORKING;
          end
        end
      end
      lrsc_pkg::TX_FAILURE: begin
        if (st.s_rest[1]) begin
          next_st.tx = lrsc_pkg::TX_NOT_ENABLED;
        end
      end
      default: next_st.tx = lrsc_pkg::TX_NOT_ENABLED;
    endcase
    next_st.fail = next_st.tx == lrsc_pkg::TX_FAILURE;
    next_st.tx_op = next_st.tx != lrsc_pkg::TX_FAILURE;
    next_st.tx_lb = st.s_txlb[1] &&
      next_st.tx != lrsc_pkg::TX_FAILURE;
    // Line output: alignment restarts at byte 0 on entry to Working
    next_st.line_valid = 1'b0;
    if (st.tx == lrsc_pkg::TX_WORKING) begin
      next_st.laser = 1'b1;
      if (fifo_valid) begin
        next_st.line = fifo_out;
        next_st.line_valid = 1'b1;
        next_st.pos = st.pos + 2'h1;
      end
    end else begin
      // Only the safety signalling may light the laser
      next_st.laser = st.tx != lrsc_pkg::TX_FAILURE && st.s_saf[1];
      next_st.line = '0;
      next_st.pos = `LRSC_RST_IDLE_BYTES;
    end
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st <= '0;
      st.rx <= lrsc_pkg::RX_RESET;
      st.tx <= lrsc_pkg::TX_NOT_ENABLED;
      st.tx_op <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      O_TX_READY <= 1'b0;
    end else begin
      O_TX_READY <= fifo_ready;
    end
  end
  assign O_RX_OPERATIONAL = st.rx_op;
  assign O_RX_STATE = st.rx;
  assign O_RX_LOOPBACK = st.rx_lb;
  assign O_TX_STATE = st.tx;
  assign O_TX_OPERATIONAL = st.tx_op;
  assign O_TX_FAILURE = st.fail;
  assign O_TX_LOOPBACK = st.tx_lb;
  assign O_DISABLE_PENDING = st.pend_dis;
  assign O_LINE_DATA = st.line.data;
  assign O_LINE_ORDERED = st.line.ordered;
  assign O_LINE_VALID = st.line_valid;
  assign O_LASER_ON = st.laser;
  assign O_LINE_BYTE_POS = st.pos;

  rx_reset_hold_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.s_rx_rst[1] |=> st.rx == lrsc_pkg::RX_RESET)
    else $error("receiver not in reset");
  // Sampled reset in the antecedent skips the release edge itself
  rx_reset_exit_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    I_RST_N && st.rx == lrsc_pkg::RX_RESET && !st.s_rx_rst[1]
    |=> st.rx == lrsc_pkg::RX_LOS)
    else $error("reset exit not to los");
  rx_width_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    $rose(st.rx == lrsc_pkg::RX_SYNC) |-> $past(st.s_width_rx[1]))
    else $error("sync without width");
  rx_sync_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.rx == lrsc_pkg::RX_LOS && !st.s_rx_rst[1] && st.s_sync[1] &&
    st.s_width_rx[1] && !st.s_sig[1] |=> st.rx == lrsc_pkg::RX_SYNC)
    else $error("sync not entered");
  rx_sig_loss_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.s_sig[1] && !st.s_rx_rst[1] |=> st.rx == lrsc_pkg::RX_LOS)
    else $error("signal loss not los");
  rx_loopback_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    O_RX_LOOPBACK |-> O_RX_STATE != lrsc_pkg::RX_RESET)
    else $error("rx loopback in reset");
  tx_open_fibre_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.s_ofc[1] && st.tx != lrsc_pkg::TX_FAILURE
    |=> st.tx == lrsc_pkg::TX_OPEN_FIBRE)
    else $error("hazard not open fibre");
  tx_of_hold_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_OPEN_FIBRE && st.s_ofc[1]
    |=> st.tx == lrsc_pkg::TX_OPEN_FIBRE)
    else $error("open fibre left early");
  tx_exit_choice_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_OPEN_FIBRE && !st.s_ofc[1] && st.s_dis[1]
    |=> st.tx == lrsc_pkg::TX_NOT_ENABLED)
    else $error("pending disable ignored");
  tx_clear_resume_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_OPEN_FIBRE && !st.s_ofc[1] && !st.s_dis[1] &&
    !st.pend_dis && !st.s_ext[1] && st.s_txw[1]
    |=> st.tx == lrsc_pkg::TX_WORKING)
    else $error("hazard clear not working");
  tx_enable_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_NOT_ENABLED && !st.s_ofc[1] && !st.s_dis[1] &&
    !st.s_ext[1] && st.s_en[1] && st.s_txw[1]
    |=> st.tx == lrsc_pkg::TX_WORKING)
    else $error("enable not working");
  tx_disable_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_WORKING && !st.s_ofc[1] && !st.s_mon[1] &&
    st.s_dis[1] |=> st.tx == lrsc_pkg::TX_NOT_ENABLED)
    else $error("disable not honoured");
  tx_width_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    $rose(st.tx == lrsc_pkg::TX_WORKING) |-> $past(st.s_txw[1]))
    else $error("working without width");
  tx_fail_entry_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_WORKING && st.s_mon[1] && !st.s_ofc[1]
    |=> st.tx == lrsc_pkg::TX_FAILURE)
    else $error("fault not failure");
  tx_fail_hold_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_FAILURE && !st.s_rest[1]
    |=> st.tx == lrsc_pkg::TX_FAILURE ##0 O_TX_FAILURE)
    else $error("failure not held");
  tx_laser_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_WORKING |=> O_LASER_ON)
    else $error("laser off in working");
  tx_laser_safe_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx != lrsc_pkg::TX_WORKING && !st.s_saf[1] |=> !O_LASER_ON)
    else $error("laser on while stopped");
  line_idle_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    st.tx != lrsc_pkg::TX_WORKING
    |=> O_LINE_BYTE_POS == 2'h0 && !O_LINE_VALID)
    else $error("line busy while stopped");
  tx_loopback_a: assert property (
    @(posedge I_CLK) disable iff (!I_RST_N)
    O_TX_LOOPBACK |-> !O_TX_FAILURE)
    else $error("tx loopback in failure");
  rx_sync_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    st.rx == lrsc_pkg::RX_LOS ##1 st.rx == lrsc_pkg::RX_SYNC);
  tx_of_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_OPEN_FIBRE ##1 st.tx == lrsc_pkg::TX_WORKING);
  tx_ne_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    st.tx == lrsc_pkg::TX_OPEN_FIBRE ##1 st.tx == lrsc_pkg::TX_NOT_ENABLED);
  tx_fail_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(O_TX_FAILURE));
  tx_full_c: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    !fifo_ready);
endmodule

// File: tb/lrsc_port_model.sv
// Port-side model that feeds whole transmission words to the block
`timescale 1ns/10ps
module lrsc_port_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [31:0] i_word,
  input wire logic i_ordered,
  input wire logic i_send,
  input wire logic i_ready,
  output logic [7:0] o_data,
  output logic o_ordered,
  output logic o_valid,
  output logic o_busy
);
  logic [31:0] word;
  logic [2:0] left;
  logic ord;
  // Whole words only, never a partial word left behind
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      left <= 3'h0;
      word <= 32'h5a5aa5a5;
      ord <= 1'b0;
    end else if (i_send && left == 3'h0) begin
      word <= i_word;
      ord <= i_ordered;
      left <= 3'h4;
    end else if (o_valid && i_ready) begin
      word <= {word[23:0], word[31:24]};
      left <= left - 3'h1;
    end
  end
  assign o_valid = (left != 3'h0);
  assign o_busy = o_valid;
  // Flag spans all four bytes, so ordered sets sit on word boundaries
  assign o_ordered = o_valid & ord;
  // Idle bus shows inverted data so stale bytes cannot pass for valid
  assign o_data = o_valid ? word[31:24] : ~word[31:24];
endmodule

// File: tb/lrsc_top_tb.sv
// Self-checking bench for the link state control block
`timescale 1ns/10ps
module lrsc_top_tb;
  logic clk = 1'b0, rst_n = 1'b0;
  logic rx_rst = 1'b0, rx_wf = 1'b0, rx_sy = 1'b0, rx_ld = 1'b0;
  logic rx_sl = 1'b0, rx_lr = 1'b0, tx_wf = 1'b0, en = 1'b0, dis = 1'b0;
  logic ext = 1'b0, haz = 1'b0, sig = 1'b0, flt = 1'b0, rest = 1'b0;
  logic tx_lr = 1'b0, p_ord = 1'b0, p_send = 1'b0;
  logic [31:0] p_word = 32'h0;
  logic [7:0] d, ld;
  logic o, v, p_busy, rdy, rx_op, rx_lb, tx_op, fail, tx_lb, pend;
  logic lo, lv, laser;
  logic [1:0] rx_st, tx_st, lpos, epos;
  logic [15:0] seed = 16'h5b38;
  logic [31:0] wd;
  logic [8:0] expq[$];
  int num_errors = 0, check_count = 0, cycles = 0;

  lrsc_port_model i_port (.i_clk(clk), .i_rst_n(rst_n), .i_word(p_word),
    .i_ordered(p_ord), .i_send(p_send), .i_ready(rdy), .o_data(d),
    .o_ordered(o), .o_valid(v), .o_busy(p_busy));
  lrsc_top i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_RX_RESET(rx_rst),
    .I_RX_WIDTH_FIXED(rx_wf), .I_RX_SYNC_ACQUIRED(rx_sy),
    .I_RX_LOS_DONE(rx_ld), .I_RX_SIGNAL_LOST(rx_sl),
    .I_RX_LOOPBACK_REQ(rx_lr), .I_TX_WIDTH_FIXED(tx_wf),
    .I_TX_ENABLE_REQ(en), .I_TX_DISABLE_REQ(dis), .I_EXT_DISABLE(ext),
    .I_OPEN_FIBRE_SAFETY_CONTROL(haz), .I_SAFETY_SIGNAL(sig),
    .I_TX_MONITOR_FAULT(flt), .I_TX_RESTORE(rest),
    .I_TX_LOOPBACK_REQ(tx_lr), .I_TX_DATA(d), .I_TX_ORDERED(o),
    .I_TX_VALID(v), .O_TX_READY(rdy), .O_RX_OPERATIONAL(rx_op),
    .O_RX_STATE(rx_st), .O_RX_LOOPBACK(rx_lb), .O_TX_STATE(tx_st),
    .O_TX_OPERATIONAL(tx_op), .O_TX_FAILURE(fail), .O_TX_LOOPBACK(tx_lb),
    .O_DISABLE_PENDING(pend), .O_LINE_DATA(ld), .O_LINE_ORDERED(lo),
    .O_LINE_VALID(lv), .O_LASER_ON(laser), .O_LINE_BYTE_POS(lpos));

  initial begin
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string nm, input logic [8:0] seen,
                       input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Two synchroniser flops plus the state flop; five edges leave margin
  // Checks read just after an edge, before that edge's updates land
  task automatic step();
    repeat (5) @(posedge clk);
  endtask

  task automatic send(input logic ordr);
    int i;
    seed = lfsr(seed);
    wd = {seed, lfsr(seed)};
    seed = lfsr(seed);
    @(posedge clk);
    p_word <= wd;
    p_ord <= ordr;
    p_send <= 1'b1;
    for (i = 3; i >= 0; i--) expq.push_back({ordr, wd[i*8+:8]});
    @(posedge clk);
    p_send <= 1'b0;
    for (i = 0; i < 40 && expq.size() != 0; i++) @(posedge clk);
  endtask

  // Line monitor: byte order and word position from Working entry
  always @(posedge clk) begin
    if (tx_st !== lrsc_pkg::TX_WORKING) epos = 2'h0;
    if (lv === 1'b1) begin
      epos = epos + 2'h1;
      if (expq.size() == 0) begin
        check("line_extra", 9'h1, 9'h0);
      end else begin
        check("line_byte", {lo, ld}, expq.pop_front());
        check("line_pos", lpos, epos);
      end
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    check("rx_state", rx_st, lrsc_pkg::RX_RESET);
    check("tx_state", tx_st, lrsc_pkg::TX_NOT_ENABLED);
    check("tx_op", tx_op, 1'b1);
    check("tx_ready", rdy, 1'b0);
    rst_n <= 1'b1;
    rx_sy <= 1'b1;
    step();
    check("rx_state", rx_st, lrsc_pkg::RX_LOS);
    check("rx_op", rx_op, 1'b1);
    rx_wf <= 1'b1;
    rx_lr <= 1'b1;
    step();
    check("rx_state", rx_st, lrsc_pkg::RX_SYNC);
    check("rx_lb", rx_lb, 1'b1);
    rx_sl <= 1'b1;
    step();
    check("rx_state", rx_st, lrsc_pkg::RX_LOS);
    rx_sl <= 1'b0;
    step();
    check("rx_state", rx_st, lrsc_pkg::RX_SYNC);
    rx_ld <= 1'b1;
    rx_sy <= 1'b0;
    step();
    check("rx_state", rx_st, lrsc_pkg::RX_LOS);
    rx_rst <= 1'b1;
    step();
    check("rx_state", rx_st, lrsc_pkg::RX_RESET);
    check("rx_op", rx_op, 1'b0);
    check("rx_lb", rx_lb, 1'b0);
    rx_rst <= 1'b0;
    step();
    check("rx_state", rx_st, lrsc_pkg::RX_LOS);
    en <= 1'b1;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_NOT_ENABLED);
    tx_wf <= 1'b1;
    tx_lr <= 1'b1;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_WORKING);
    check("laser", laser, 1'b1);
    check("tx_lb", tx_lb, 1'b1);
    check("tx_ready", rdy, 1'b1);
    send(1'b1);
    send(1'b0);
    send(1'b0);
    haz <= 1'b1;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_OPEN_FIBRE);
    check("laser", {laser, tx_op}, 2'h1);
    sig <= 1'b1;
    en <= 1'b0;
    dis <= 1'b1;
    step();
    check("laser", laser, 1'b1);
    check("tx_state", tx_st, lrsc_pkg::TX_OPEN_FIBRE);
    check("pend", pend, 1'b1);
    sig <= 1'b0;
    haz <= 1'b0;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_NOT_ENABLED);
    haz <= 1'b1;
    step();
    dis <= 1'b0;
    en <= 1'b1;
    step();
    check("pend", pend, 1'b0);
    haz <= 1'b0;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_WORKING);
    send(1'b0);
    dis <= 1'b1;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_NOT_ENABLED);
    dis <= 1'b0;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_WORKING);
    flt <= 1'b1;
    step();
    flt <= 1'b0;
    en <= 1'b0;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_FAILURE);
    check("tx_fail", {fail, tx_op, tx_lb}, 3'h4);
    rest <= 1'b1;
    step();
    rest <= 1'b0;
    en <= 1'b1;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_WORKING);
    ext <= 1'b1;
    step();
    check("tx_state", tx_st, lrsc_pkg::TX_NOT_ENABLED);
    end_of_test();
  end
endmodule
